// file: rtl/arc_ctrl.sv
// Converter control: prescaler, result pair with read lock, auto trigger, pin disables
//
// Functional notes
// - Interrupt requested only with enable and global enable
// - 3-bit prescaler divides 2,2,4..128
// - Result low byte at base, high at base+1
// - Finished conversion loads result bytes
// - Low byte read locks pair until high read
// - Clear align bit right-aligns 10-bit result
// - Set align bit left-aligns result
// - High-only read needs no lock
// - Comparator mux routed when enabled and converter off
// - Trigger source ignored without auto-trigger
// - Auto-trigger starts on selected flag rising edge
// - Source switch from clear to set triggers
// - Switching to free-running never triggers
// - Trigger source code table
// - Disable bit kills buffer, port bit reads zero
// - Done flag set on update, cleared by vector or one
// - Align change affects view immediately
// - First conversion 25 clocks, later ones 13
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
module arc_ctrl
   import arc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   input wire arc_pkg::arc_trig_flags_s trig_flags,
   input wire logic [9:0] core_result,
   input wire logic core_result_valid,
   input wire logic [7:0] pin_raw,
   output logic conv_clock_en,
   output logic core_start,
   output logic core_first,
   output logic [4:0] channel_gain_field,
   output logic comparator_mux_sel,
   output logic [7:0] pin_buffer_off,
   output logic [7:0] port_pin_value,
   output logic conv_irq
);
   import arc_pkg::*;

   logic [7:0] ctrl_a_q;
   logic [7:0] ctrl_b_q;
   logic [7:0] pin_disable_q;
   logic [7:0] input_sel_q;
   logic [9:0] result_q;
   logic lock_q;
   logic done_q;
   logic busy_q;
   logic initialized_q;
   logic [6:0] presc_cnt_q;
   logic [4:0] conv_cnt_q;
   logic trig_sel_q;
   logic [7:0] pin_sync1_q;
   logic [7:0] pin_sync2_q;
   arc_state_e state_q;
   logic trig_sel;
   logic trig_edge;
   logic conv_tick;
   logic conv_finish;
   logic sw_start;
   logic start_conv;
   logic [15:0] view;
   logic [6:0] presc_limit;
   logic [7:0] rdata_d;

   // Division minus one; codes 000 and 001 both divide by two
   function automatic logic [6:0] presc_div(input logic [2:0] code);
      logic [6:0] lim;
      lim = 7'h01;
      if (code > 3'h1)
      begin
         lim = PRESCALE_MAX >> (3'h7 - code);
      end
      return lim;
   endfunction

   function automatic logic pick_flag(input logic [2:0] code, input arc_trig_flags_s f, input logic done);
      logic v;
      v = 1'b0;
      case (code)
         3'h0: v = done;
         3'h1: v = f.cmp;
         3'h2: v = f.ext_int0;
         3'h3: v = f.t0_cmp_a;
         3'h4: v = f.t0_ovf;
         3'h5: v = f.t1_cmp_b;
         3'h6: v = f.t1_ovf;
         default: v = f.t1_capture;
      endcase
      return v;
   endfunction

   assign presc_limit = presc_div(ctrl_a_q[2:0]);
   assign conv_tick = ctrl_a_q[CA_ENABLE] && (presc_cnt_q == presc_limit);
   // Free-running selects done flag as level, but the edge is masked below
   assign trig_sel = pick_flag(ctrl_b_q[2:0], trig_flags, done_q);
   assign trig_edge = ctrl_a_q[CA_AUTO] && trig_sel && !trig_sel_q
      && (ctrl_b_q[2:0] != TRIG_FREE_RUN);
   assign sw_start = bus_wr && (bus_addr == ADDR_CTRL_A) && bus_wdata[CA_START];
   assign start_conv = ctrl_a_q[CA_ENABLE] && !busy_q && (sw_start || trig_edge
      || (ctrl_a_q[CA_AUTO] && ctrl_b_q[2:0] == TRIG_FREE_RUN && state_q == ST_DONE));
   assign conv_finish = busy_q && conv_tick && (conv_cnt_q == 5'd1);

   // Prescaler runs only while the converter is enabled
   always_ff @(posedge clk_sys)
   begin
      if (reset || !ctrl_a_q[CA_ENABLE] || conv_tick)
      begin
         presc_cnt_q <= 7'h00;
      end
      else
      begin
         presc_cnt_q <= presc_cnt_q + 7'h01;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         conv_clock_en <= 1'b0;
      end
      else
      begin
         conv_clock_en <= conv_tick;
      end
   end

   // Conversion sequencer
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         state_q <= ST_IDLE;
         busy_q <= 1'b0;
         conv_cnt_q <= 5'd0;
         initialized_q <= 1'b0;
         core_start <= 1'b0;
         core_first <= 1'b0;
      end
      else
      begin
         core_start <= 1'b0;
         if (!ctrl_a_q[CA_ENABLE])
         begin
            // Disabling aborts and forces the long init conversion next
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            initialized_q <= 1'b0;
         end
         else
         begin
            case (state_q)
               ST_IDLE, ST_DONE:
               begin
                  state_q <= ST_IDLE;
                  if (start_conv)
                  begin
                     state_q <= ST_CONV;
                     busy_q <= 1'b1;
                     core_start <= 1'b1;
                     core_first <= !initialized_q;
                     conv_cnt_q <= initialized_q ? NORMAL_CONV_CYCLES : FIRST_CONV_CYCLES;
                  end
               end
               ST_CONV:
               begin
                  if (conv_tick)
                  begin
                     conv_cnt_q <= conv_cnt_q - 5'd1;
                  end
                  if (conv_finish)
                  begin
                     state_q <= ST_DONE;
                     busy_q <= 1'b0;
                     initialized_q <= 1'b1;
                  end
               end
               default:
               begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Result capture honours the read lock
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         result_q <= RESULT_RESET;
      end
      else if (core_result_valid && !lock_q)
      begin
         result_q <= core_result;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         lock_q <= 1'b0;
      end
      else if (bus_rd && bus_addr == ADDR_RESULT_HIGH)
      begin
         lock_q <= 1'b0;
      end
      else if (bus_rd && bus_addr == ADDR_RESULT_LOW)
      begin
         lock_q <= 1'b1;
      end
   end

   // Done flag: set wins over clear
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         done_q <= 1'b0;
      end
      else if (core_result_valid && !lock_q)
      begin
         done_q <= 1'b1;
      end
      else if (irq_vector_ack || (bus_wr && bus_addr == ADDR_CTRL_A && bus_wdata[CA_DONE]))
      begin
         done_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         trig_sel_q <= 1'b0;
      end
      else
      begin
         trig_sel_q <= trig_sel;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         ctrl_a_q <= CTRL_A_RESET;
         ctrl_b_q <= CTRL_B_RESET;
         pin_disable_q <= PIN_DISABLE_RESET;
         input_sel_q <= INPUT_SELECT_RESET;
      end
      else if (bus_wr)
      begin
         if (bus_addr == ADDR_CTRL_A)
         begin
            // Start and done are held elsewhere; stored copies stay zero
            ctrl_a_q <= {bus_wdata[7], 1'b0, bus_wdata[5], 1'b0, bus_wdata[3:0]};
         end
         else if (bus_addr == ADDR_CTRL_B)
         begin
            ctrl_b_q <= {1'b0, bus_wdata[6], 3'b000, bus_wdata[2:0]};
         end
         else if (bus_addr == ADDR_PIN_DISABLE)
         begin
            pin_disable_q <= bus_wdata;
         end
         else if (bus_addr == ADDR_INPUT_SELECT)
         begin
            input_sel_q <= bus_wdata;
         end
      end
   end

   // Alignment is applied on read so it changes at once
   assign view = input_sel_q[IS_LEFT_ALIGN] ? {result_q, 6'b000000}
      : {6'b000000, result_q};

   always_comb
   begin
      rdata_d = 8'h00;
      if (bus_addr == ADDR_RESULT_LOW)
      begin
         rdata_d = view[7:0];
      end
      else if (bus_addr == ADDR_RESULT_HIGH)
      begin
         rdata_d = view[15:8];
      end
      else if (bus_addr == ADDR_CTRL_A)
      begin
         rdata_d = {ctrl_a_q[7], busy_q, ctrl_a_q[5], done_q, ctrl_a_q[3:0]};
      end
      else if (bus_addr == ADDR_CTRL_B)
      begin
         rdata_d = ctrl_b_q;
      end
      else if (bus_addr == ADDR_PIN_DISABLE)
      begin
         rdata_d = pin_disable_q;
      end
      else if (bus_addr == ADDR_INPUT_SELECT)
      begin
         rdata_d = input_sel_q;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         bus_rdata <= 8'h00;
      end
      else if (bus_rd)
      begin
         bus_rdata <= rdata_d;
      end
      else
      begin
         bus_rdata <= 8'h00;
      end
   end

   // Pin values are asynchronous, so two stages first
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         pin_sync1_q <= 8'h00;
         pin_sync2_q <= 8'h00;
      end
      else
      begin
         pin_sync1_q <= pin_raw;
         pin_sync2_q <= pin_sync1_q;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         port_pin_value <= 8'h00;
         pin_buffer_off <= 8'h00;
         comparator_mux_sel <= 1'b0;
         conv_irq <= 1'b0;
         channel_gain_field <= 5'h00;
      end
      else
      begin
         port_pin_value <= pin_sync2_q & ~pin_disable_q;
         pin_buffer_off <= pin_disable_q;
         comparator_mux_sel <= ctrl_b_q[CB_CMP_MUX] && !ctrl_a_q[CA_ENABLE];
         conv_irq <= done_q && ctrl_a_q[CA_IRQ_EN] && global_irq_enable;
         channel_gain_field <= input_sel_q[4:0];
      end
   end
endmodule

// file: rtl/arc_pkg.sv
// Package: register map, field layout and constants for the converter control block
package arc_pkg;
   localparam logic [7:0] ADDR_RESULT_LOW = 8'h78;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'h79;
   localparam logic [7:0] ADDR_CTRL_A = 8'h7A;
   localparam logic [7:0] ADDR_CTRL_B = 8'h7B;
   localparam logic [7:0] ADDR_PIN_DISABLE = 8'h7E;
   localparam logic [7:0] ADDR_INPUT_SELECT = 8'h7C;
   // Control A fields
   localparam int CA_ENABLE = 7;
   localparam int CA_START = 6;
   localparam int CA_AUTO = 5;
   localparam int CA_DONE = 4;
   localparam int CA_IRQ_EN = 3;
   // Control B / input select fields
   localparam int CB_CMP_MUX = 6;
   localparam int IS_LEFT_ALIGN = 5;
   localparam int IS_DIFF_LO = 3;
   localparam logic [7:0] CTRL_A_RESET = 8'h00;
   localparam logic [7:0] CTRL_B_RESET = 8'h00;
   localparam logic [7:0] PIN_DISABLE_RESET = 8'h00;
   localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
   localparam logic [9:0] RESULT_RESET = 10'h000;
   localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
   // Conversion lengths in converter clocks
   localparam logic [4:0] FIRST_CONV_CYCLES = 5'd25;
   localparam logic [4:0] NORMAL_CONV_CYCLES = 5'd13;
   localparam logic [6:0] PRESCALE_MAX = 7'h7F;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } arc_bus_req_s;

   typedef struct packed {
      logic cmp;
      logic ext_int0;
      logic t0_cmp_a;
      logic t0_ovf;
      logic t1_cmp_b;
      logic t1_ovf;
      logic t1_capture;
   } arc_trig_flags_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CONV = 3'b010,
      ST_DONE = 3'b100
   } arc_state_e;
endpackage

// file: verification/arc_ctrl_chk.sv
// Port-level assertions for the converter control block
`timescale 1ns/10ps
module arc_ctrl_chk
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_rdata,
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   input wire logic core_result_valid,
   input wire logic conv_clock_en,
   input wire logic core_start,
   input wire logic comparator_mux_sel,
   input wire logic [7:0] pin_buffer_off,
   input wire logic [7:0] port_pin_value,
   input wire logic conv_irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Ack with no fresh result on either cycle
   sequence ack_quiet_s;
      irq_vector_ack && !core_result_valid ##1 !core_result_valid;
   endsequence
   irq_gate_a: assert property (conv_irq |-> $past(global_irq_enable)) else $error("irq without global enable");
   irq_clear_a: assert property (ack_quiet_s |=> !conv_irq) else $error("irq survives vector ack");
   rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00) else $error("read data without read");
   pin_mask_a: assert property ((port_pin_value & pin_buffer_off) == 8'h00) else $error("disabled pin reads one");
   pin_write_a: assert property ($changed(pin_buffer_off) |-> $past(bus_wr) || $past(bus_wr, 2))
      else $error("pin disables moved without write");
   mux_cause_a: assert property ($rose(comparator_mux_sel) |-> $past(bus_wr) || $past(bus_wr, 2))
      else $error("mux select rose without write");
   tick_gap_a: assert property (conv_clock_en |=> !conv_clock_en) else $error("converter tick faster than half");
   start_pulse_a: assert property (core_start |=> !core_start) else $error("start longer than one cycle");
endmodule

// file: verification/arc_core_model.sv
// Behavioural converter core answering each start after its tick count
`timescale 1ns/10ps
module arc_core_model
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic core_start,
   input wire logic core_first,
   input wire logic conv_clock_en,
   input wire logic [9:0] sample,
   output logic [9:0] core_result,
   output logic core_result_valid
);
   import arc_pkg::*;
   logic [4:0] left_q;
   always_ff @(posedge clk_sys)
   begin
      core_result_valid <= 1'b0;
      if (reset)
         left_q <= 5'h00;
      else if (core_start)
         left_q <= core_first ? FIRST_CONV_CYCLES : NORMAL_CONV_CYCLES;
      else if (left_q != 5'h00 && conv_clock_en)
      begin
         left_q <= left_q - 5'h01;
         core_result_valid <= (left_q == 5'h01);
      end
   end
   // Bus is junk outside the valid pulse so a late sample is caught
   assign core_result = core_result_valid ? sample : ~sample;
endmodule

// file: verification/adc_result_and_trigger_ctrl_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module adc_result_and_trigger_ctrl_test;
   import arc_pkg::*;
   logic clk_sys, reset, bus_wr, bus_rd, global_irq_enable, irq_vector_ack, core_result_valid;
   logic conv_clock_en, core_start, core_first, comparator_mux_sel, conv_irq;
   logic [7:0] bus_addr, bus_wdata, bus_rdata, pin_raw, pin_buffer_off, port_pin_value;
   logic [9:0] core_result, sample;
   logic [4:0] channel_gain_field;
   arc_trig_flags_s trig_flags;
   int n_fail = 0, tests_run = 0, cyc = 0, i, n;
   // Address, write data, read back
   logic [7:0] rows [7][3] = '{'{8'h7A, 8'h00, 8'h00}, '{8'h7E, 8'hA5, 8'hA5}, '{8'h7B, 8'hFF, 8'h47},
      '{8'h7F, 8'hFF, 8'h00}, '{8'h78, 8'hFF, 8'h00}, '{8'h79, 8'hFF, 8'h00}, '{8'h7C, 8'h3F, 8'h3F}};
   arc_ctrl i_arc_ctrl (.clk_sys, .reset, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .global_irq_enable,
      .irq_vector_ack, .trig_flags, .core_result, .core_result_valid, .pin_raw, .conv_clock_en, .core_start,
      .core_first, .channel_gain_field, .comparator_mux_sel, .pin_buffer_off, .port_pin_value, .conv_irq);
   arc_core_model i_arc_core_model (.clk_sys, .reset, .core_start, .core_first, .conv_clock_en, .sample,
      .core_result, .core_result_valid);
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      {bus_addr, bus_wdata, bus_wr} <= {a, d, 1'b1};
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge clk_sys);
      {bus_addr, bus_rd} <= {a, 1'b1};
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1 chk(name, exp, bus_rdata);
   endtask
   task automatic wait_hi(ref logic s, input int lim, input string name);
      // Step off the edge so a pulse launched there is seen settled
      #1;
      for (int k = 0; k < lim && s !== 1'b1; k++)
         @(posedge clk_sys) #1;
      chk(name, 8'h01, {7'h00, s});
   endtask
   task automatic stay_lo(ref logic s, input string name);
      logic seen = 1'b0;
      repeat (8)
         @(posedge clk_sys) #1 seen |= s;
      chk(name, 8'h00, {7'h00, seen});
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Longest path is the prescaler sweep, about 600 cycles
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 8000)
      begin
         n_fail++;
         report_and_stop();
      end
   end
   initial
   begin
      {bus_wr, bus_rd, irq_vector_ack, bus_addr, bus_wdata, trig_flags} = '0;
      {reset, global_irq_enable, pin_raw, sample} = {1'b1, 1'b1, 8'hFF, 10'h2B5};
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      foreach (rows[r])
      begin
         rd(rows[r][0], 8'h00, "reset value");
         wr(rows[r][0], rows[r][1]);
         rd(rows[r][0], rows[r][2], "readback");
      end
      chk("pin value", 8'h5A, port_pin_value);
      chk("cmp mux off", 8'h01, {7'h00, comparator_mux_sel});
      chk("pin buffer", 8'hA5, pin_buffer_off);
      chk("channel", 8'h1F, {3'h0, channel_gain_field});
      $display("registers done");
      for (i = 0; i < 8; i++)
      begin
         wr(8'h7A, 8'h80 | i[7:0]);
         wait_hi(conv_clock_en, 300, "tick");
         n = 0;
         do
            @(posedge clk_sys) #1 n++;
         while (conv_clock_en !== 1'b1 && n < 300);
         chk("divide", (i < 2) ? 8'h02 : 8'h01 << i, n[7:0]);
      end
      chk("cmp mux on", 8'h00, {7'h00, comparator_mux_sel});
      $display("prescaler done");
      wr(8'h7C, 8'h00);
      wr(8'h7A, 8'h89);
      wr(8'h7A, 8'hC9);
      wait_hi(conv_irq, 200, "irq");
      chk("first conv", 8'h01, {7'h00, core_first});
      rd(8'h78, 8'hB5, "low right");
      rd(8'h79, 8'h02, "high right");
      wr(8'h7C, 8'h20);
      rd(8'h79, 8'hAD, "high left");
      rd(8'h78, 8'h40, "low left");
      @(posedge clk_sys) global_irq_enable <= 1'b0;
      stay_lo(conv_irq, "irq masked");
      @(posedge clk_sys) {global_irq_enable, irq_vector_ack} <= 2'b11;
      @(posedge clk_sys) irq_vector_ack <= 1'b0;
      stay_lo(conv_irq, "irq acked");
      sample <= 10'h3FF;
      wr(8'h7A, 8'hC9);
      wait_hi(core_result_valid, 200, "locked result");
      stay_lo(conv_irq, "locked flag");
      chk("later conv", 8'h00, {7'h00, core_first});
      rd(8'h78, 8'h40, "locked low");
      rd(8'h79, 8'hAD, "locked high");
      wr(8'h7A, 8'hC9);
      wait_hi(conv_irq, 200, "irq");
      rd(8'h79, 8'hFF, "high only");
      sample <= 10'h155;
      wr(8'h7A, 8'hC9);
      rd(8'h7A, 8'hD9, "busy");
      wait_hi(core_result_valid, 200, "unlocked result");
      rd(8'h79, 8'h55, "no lock");
      rd(8'h7A, 8'h99, "idle");
      wr(8'h7A, 8'h99);
      rd(8'h7A, 8'h89, "flag cleared");
      $display("results done");
      wr(8'h7A, 8'hA9);
      for (i = 1; i < 8; i++)
      begin
         wr(8'h7B, i[7:0]);
         @(posedge clk_sys) trig_flags <= 7'h01 << (7 - i);
         wait_hi(core_start, 6, "auto start");
         wait_hi(core_result_valid, 60, "auto done");
         @(posedge clk_sys) trig_flags <= '0;
      end
      wr(8'h7B, 8'h01);
      @(posedge clk_sys) trig_flags <= 7'h01;
      stay_lo(core_start, "unselected flag");
      wr(8'h7B, 8'h07);
      wait_hi(core_start, 6, "source switch");
      wait_hi(core_result_valid, 60, "switch done");
      wr(8'h7B, 8'h00);
      stay_lo(core_start, "free run switch");
      wr(8'h7A, 8'hE9);
      wait_hi(core_result_valid, 60, "free run done");
      wait_hi(core_start, 6, "free run restart");
      wr(8'h7A, 8'h89);
      // Let the running conversion end so a refused start is visible
      wait_hi(core_result_valid, 60, "free run stop");
      wr(8'h7B, 8'h01);
      @(posedge clk_sys) trig_flags <= 7'h40;
      stay_lo(core_start, "auto off");
      $display("trigger done");
      report_and_stop();
   end
endmodule
bind arc_ctrl arc_ctrl_chk i_arc_ctrl_chk (.clk_sys, .reset, .bus_wr, .bus_rd, .bus_rdata, .global_irq_enable,
   .irq_vector_ack, .core_result_valid, .conv_clock_en, .core_start, .comparator_mux_sel, .pin_buffer_off,
   .port_pin_value, .conv_irq);
